// [pkg/monitor_link_pkg.sv]
// constants, state codes and timing counts for the monitor entry link
// assumes one 125 MHz clock that also stands in for the oscillator input
package monitor_link_pkg;

  // clock rate, used only to document the bit time in nanoseconds
  localparam int unsigned CLK_HZ         = 125_000_000;

  // bus clock dividers applied to the oscillator input
  localparam int unsigned DIV_NORMAL     = 2;
  localparam int unsigned DIV_FORCED     = 4;

  // bus cycles per bit on the host link
  localparam int unsigned BAUD_DIVISOR   = 278;

  // oscillator cycles per bit for each divider setting
  localparam logic [11:0] BIT_CYC_DIV2   = 12'(BAUD_DIVISOR * DIV_NORMAL);
  localparam logic [11:0] BIT_CYC_DIV4   = 12'(BAUD_DIVISOR * DIV_FORCED);

  // erased value of a reset vector byte
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

  // framing and sequencing counts
  localparam logic [3:0]  FRAME_BITS     = 4'hA;
  localparam logic [3:0]  BREAK_BITS     = 4'hA;
  localparam logic [1:0]  GAP_BITS       = 2'h2;
  localparam logic [3:0]  SECURITY_BYTES = 4'h8;
  localparam logic [9:0]  BREAK_PATTERN  = 10'h000;

  // stream and buffer shape
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned TX_FIFO_DEPTH  = 4;

  // link sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_CAPTURE = 6'h01,
    ST_USER    = 6'h02,
    ST_IDLE    = 6'h04,
    ST_RX      = 6'h08,
    ST_GAP     = 6'h10,
    ST_TX      = 6'h20
  } link_state_t;

endpackage : monitor_link_pkg

// [pkg/byte_stream_if.sv]
// valid/ready byte stream between the link top and its transmit buffer
// assumes both ends share one clock
interface byte_stream_if #(
  parameter int unsigned W = 8
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface : byte_stream_if

// [verilog/tx_fifo.sv]
// small first-in first-out buffer for bytes waiting to go out on the link
// assumes a synchronous active-high reset and a consumer that may stall
module tx_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic     clk,
  input  wire logic     rst,
  byte_stream_if.sink   fill,
  byte_stream_if.source drain
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [AW:0]             count;
    logic                    room;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic        push;
  logic        pop;

  ////////////////////////////////////////////////////////////////////////
  // ready comes from a flop so the top can hand it out unchanged
  assign fill.ready  = s_q.room;
  assign drain.valid = (s_q.count != '0);
  assign drain.data  = s_q.mem[s_q.rd_ptr];
  assign push        = fill.valid & s_q.room;
  assign pop         = drain.valid & drain.ready;

  // pointer and count update; simultaneous push and pop keep the count
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr_ptr] = fill.data;
      s_d.wr_ptr          = AW'(s_q.wr_ptr + 1'b1);
    end
    if (pop) begin
      s_d.rd_ptr = AW'(s_q.rd_ptr + 1'b1);
    end
    s_d.count = (AW+1)'(s_q.count + {{AW{1'b0}}, push}
                        - {{AW{1'b0}}, pop});
    s_d.room  = (s_d.count != FULL_COUNT);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : tx_fifo

// [verilog/monitor_link.sv]
// monitor mode entry and single-wire host link
// assumes straps, vector bytes and the serial pin are synchronous to clk;
// rst models the reset pin, power_on_reset tells a power-on cause
//
// Notes on behaviour
// R1: erased vector allows entry without test voltage
// R2: all host traffic uses the single serial pin
// R3: serial pin is wired-OR, only pulled low
// R4: both directions use NRZ start/stop framing
// R5: bit rate is bus frequency over 278
// R6: normal entry, divider pin low: bus /2
// R7: divider pin high or forced entry: bus /4
// R8: host holds entry straps during reset
// R9: forced entry needs only serial and select straps
// R10: monitor keeps watchdog and PLL off
// R11: entry qualified only on power-on reset
// R12: commands reach memory, downloaded code runs
// R13: other pins keep their normal functions
// R14: mode latched at reset release, straps then free
// R15: after eight security bytes, send break
// R16: on break, release two bits, echo break
// R17: every received byte is echoed back
module monitor_link (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              power_on_reset,
  input  wire logic              high_test_voltage,
  input  wire logic [7:0]        reset_vector_high,
  input  wire logic [7:0]        reset_vector_low,
  input  wire logic              entry_select_pin,
  input  wire logic              mode_select_pin_0,
  input  wire logic              mode_select_pin_1,
  input  wire logic              bus_divider_select_pin,
  input  wire logic              host_serial_pin_in,
  output logic                   host_serial_pin_out,
  output logic                   host_serial_pin_oe,
  output logic                   monitor_mode,
  output logic                   forced_monitor,
  output logic                   bus_div4,
  output logic                   bus_clk,
  output logic                   watchdog_enable,
  output logic                   pll_enable,
  output logic                   monitor_pin_claim,
  output logic                   security_done,
  output logic [7:0]             rx_data,
  output logic                   rx_strobe,
  output logic                   rx_break,
  input  wire logic [7:0]        tx_data,
  input  wire logic              tx_valid,
  output logic                   tx_ready
);

  typedef struct packed {
    monitor_link_pkg::link_state_t st;
    logic        mon;
    logic        forced;
    logic        div4;
    logic        wd_en;
    logic        pll_en;
    logic        claim;
    logic [1:0]  bdiv;
    logic        bus_clk;
    logic [11:0] tmr;
    logic [3:0]  bitn;
    logic [9:0]  shf;
    logic        brk;
    logic [3:0]  sec;
    logic        brk_pend;
    logic        sec_done;
    logic        pin_oe;
    logic [7:0]  rx_data;
    logic        rx_stb;
    logic        rx_brk;
  } link_regs_t;

  link_regs_t s_q;
  link_regs_t s_d;

  byte_stream_if #(.W(monitor_link_pkg::DATA_W)) tx_fill  ();
  byte_stream_if #(.W(monitor_link_pkg::DATA_W)) tx_drain ();

  logic erased;
  logic link_straps;
  logic normal_entry;
  logic forced_entry;

  // oscillator cycles in one bit for the latched divider
  function automatic logic [11:0] bit_len(input logic div4);
    return div4 ? monitor_link_pkg::BIT_CYC_DIV4
                : monitor_link_pkg::BIT_CYC_DIV2;
  endfunction : bit_len

  ////////////////////////////////////////////////////////////////////////
  // transmit buffer: the link drains it only while idle, so it can fill
  assign tx_fill.data  = tx_data;
  assign tx_fill.valid = tx_valid;
  assign tx_ready      = tx_fill.ready;

  tx_fifo #(
    .W     (monitor_link_pkg::DATA_W),
    .DEPTH (monitor_link_pkg::TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk   (clk),
    .rst   (rst),
    .fill  (tx_fill.sink),
    .drain (tx_drain.source)
  );

  ////////////////////////////////////////////////////////////////////////
  // entry qualification from straps and vector contents
  assign erased = (reset_vector_high == monitor_link_pkg::ERASED_BYTE) &&
                  (reset_vector_low == monitor_link_pkg::ERASED_BYTE); // [R1]
  // serial pin high and select low are needed for both entries
  assign link_straps  = host_serial_pin_in & ~entry_select_pin; // [R8] [R9]
  assign normal_entry = high_test_voltage & link_straps &
                        mode_select_pin_0 & ~mode_select_pin_1; // [R8]
  assign forced_entry = ~high_test_voltage & erased &
                        link_straps; // [R1] [R9]

  ////////////////////////////////////////////////////////////////////////
  // next-state logic for mode latch, bus divider and serial sequencer
  always_comb begin
    s_d        = s_q;
    s_d.rx_stb = 1'b0;
    s_d.rx_brk = 1'b0;
    tx_drain.ready = 1'b0;

    // bus clock from the oscillator input, /2 or /4
    s_d.bdiv    = 2'(s_q.bdiv + 1'b1);
    s_d.bus_clk = s_q.div4 ? s_q.bdiv[1] : s_q.bdiv[0]; // [R6] [R7]

    unique case (s_q.st)
      // one look at the straps right after reset release
      monitor_link_pkg::ST_CAPTURE: begin
        if (power_on_reset && (normal_entry || forced_entry)) begin // [R11]
          s_d.mon    = 1'b1; // [R14]
          s_d.forced = forced_entry;
          // forced entry ignores the divider pin
          s_d.div4   = forced_entry | bus_divider_select_pin; // [R6] [R7]
          s_d.wd_en  = 1'b0; // [R10]
          s_d.pll_en = 1'b0; // [R10]
          s_d.claim  = 1'b1; // [R2] [R13]
          s_d.st     = monitor_link_pkg::ST_IDLE;
        end else begin
          s_d.wd_en  = 1'b1; // [R10]
          s_d.pll_en = 1'b1;
          s_d.div4   = 1'b1;
          s_d.st     = monitor_link_pkg::ST_USER;
        end
      end

      // user mode: link stays released, straps no longer looked at
      monitor_link_pkg::ST_USER: begin
        s_d.st = monitor_link_pkg::ST_USER; // [R14]
      end

      // line idle: an incoming start bit wins over anything to send
      monitor_link_pkg::ST_IDLE: begin
        if (!host_serial_pin_in) begin
          s_d.st   = monitor_link_pkg::ST_RX;
          s_d.tmr  = 12'(bit_len(s_q.div4) >> 1); // sample mid-bit
          s_d.bitn = 4'h0;
          s_d.shf  = 10'h000;
        end else if (s_q.brk_pend) begin
          // ready-for-command break after the security bytes
          s_d.brk_pend = 1'b0;
          s_d.sec_done = 1'b1; // [R15]
          s_d.shf      = monitor_link_pkg::BREAK_PATTERN; // [R15]
          s_d.bitn     = 4'h0;
          s_d.tmr      = 12'(bit_len(s_q.div4) - 1'b1);
          s_d.pin_oe   = 1'b1; // [R3]
          s_d.st       = monitor_link_pkg::ST_TX;
        end else if (s_q.sec_done && tx_drain.valid) begin
          // firmware replies are held back until security passes
          tx_drain.ready = 1'b1;
          s_d.shf    = {1'b1, tx_drain.data, 1'b0}; // [R4]
          s_d.bitn   = 4'h0;
          s_d.tmr    = 12'(bit_len(s_q.div4) - 1'b1);
          s_d.pin_oe = 1'b1; // [R3]
          s_d.st     = monitor_link_pkg::ST_TX;
        end
      end

      // shift in start, eight data bits and the stop position
      monitor_link_pkg::ST_RX: begin
        if (s_q.tmr == 12'h000) begin
          s_d.shf  = {host_serial_pin_in, s_q.shf[9:1]}; // [R4]
          s_d.bitn = 4'(s_q.bitn + 1'b1);
          s_d.tmr  = 12'(bit_len(s_q.div4) - 1'b1); // [R5]
          if (s_q.bitn == 4'(monitor_link_pkg::FRAME_BITS - 1'b1)) begin
            // ten zeros including the stop slot is a break
            s_d.brk = ({host_serial_pin_in, s_q.shf[9:1]} ==
                       monitor_link_pkg::BREAK_PATTERN); // [R16]
            // two bit times released before any echo
            s_d.tmr = 12'(bit_len(s_q.div4) *
                          monitor_link_pkg::GAP_BITS - 1'b1); // [R16]
            s_d.st  = monitor_link_pkg::ST_GAP;
          end
        end else begin
          s_d.tmr = 12'(s_q.tmr - 1'b1);
        end
      end

      // pin left to the pullup, then echo the frame or the break
      monitor_link_pkg::ST_GAP: begin
        if (s_q.tmr == 12'h000) begin
          s_d.bitn   = 4'h0;
          s_d.tmr    = 12'(bit_len(s_q.div4) - 1'b1);
          s_d.st     = monitor_link_pkg::ST_TX;
          if (s_q.brk) begin
            s_d.shf    = monitor_link_pkg::BREAK_PATTERN; // [R16]
            s_d.rx_brk = 1'b1;
            s_d.pin_oe = 1'b1;
          end else begin
            s_d.shf     = {1'b1, s_q.shf[8:1], 1'b0}; // [R17]
            s_d.pin_oe  = 1'b1; // [R3]
            // received byte to the monitor firmware
            s_d.rx_data = s_q.shf[8:1]; // [R12]
            s_d.rx_stb  = 1'b1;
            if (!s_q.sec_done && !s_q.brk_pend) begin
              s_d.sec = 4'(s_q.sec + 1'b1);
              if (s_d.sec == monitor_link_pkg::SECURITY_BYTES) begin
                s_d.brk_pend = 1'b1; // [R15]
              end
            end
          end
        end else begin
          s_d.tmr = 12'(s_q.tmr - 1'b1);
        end
      end

      // shift out lsb first; a one releases the pin, a zero pulls it low
      monitor_link_pkg::ST_TX: begin
        if (s_q.tmr == 12'h000) begin
          if (s_q.bitn == 4'(monitor_link_pkg::BREAK_BITS - 1'b1)) begin
            s_d.pin_oe = 1'b0;
            s_d.st     = monitor_link_pkg::ST_IDLE;
          end else begin
            s_d.shf    = {1'b1, s_q.shf[9:1]};
            s_d.bitn   = 4'(s_q.bitn + 1'b1);
            s_d.pin_oe = ~s_q.shf[1]; // [R3]
            s_d.tmr    = 12'(bit_len(s_q.div4) - 1'b1); // [R5]
          end
        end else begin
          s_d.tmr = 12'(s_q.tmr - 1'b1);
        end
      end

      default: begin
        s_d.st = monitor_link_pkg::ST_CAPTURE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // single register stage for all state
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q    <= '0;
      s_q.st <= monitor_link_pkg::ST_CAPTURE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from state flops, except host_serial_pin_out tied low
  assign host_serial_pin_out = 1'b0; // only ever pulls low [R3]
  assign host_serial_pin_oe  = s_q.pin_oe; // [R2]
  assign monitor_mode        = s_q.mon;
  assign forced_monitor      = s_q.forced;
  assign bus_div4            = s_q.div4;
  assign bus_clk             = s_q.bus_clk;
  assign watchdog_enable     = s_q.wd_en;
  assign pll_enable          = s_q.pll_en;
  assign monitor_pin_claim   = s_q.claim; // [R13]
  assign security_done       = s_q.sec_done;
  assign rx_data             = s_q.rx_data;
  assign rx_strobe           = s_q.rx_stb;
  assign rx_break            = s_q.rx_brk;

endmodule : monitor_link

// [bench/link_sva.sv]
// checker for the monitor link top-level ports
// assumes a bind into monitor_link, one clock, synchronous reset
module link_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic host_serial_pin_oe,
  input wire logic monitor_mode,
  input wire logic forced_monitor,
  input wire logic bus_div4,
  input wire logic bus_clk,
  input wire logic watchdog_enable,
  input wire logic pll_enable,
  input wire logic security_done,
  input wire logic rx_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT2 = 556;
  localparam int BIT4 = 1112;
  logic        oe_q;
  logic [15:0] run_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // cycles the line stays pulled low, judged in whole bits on release
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_q  <= 1'b0;
      run_q <= 16'h0000;
    end else begin
      oe_q  <= host_serial_pin_oe;
      run_q <= (host_serial_pin_oe != oe_q) ? 16'h0001 : run_q + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // modes are read two edges after the reset pin is released
  sequence s_release;
    $fell(rst);
  endsequence
  sequence s_settled;
    s_release ##1 (!rst)[*2];
  endsequence

  property p_wd_off;
    monitor_mode |-> !watchdog_enable && !pll_enable;
  endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("watchdog or pll on in monitor mode");

  property p_user_on;
    s_settled |-> watchdog_enable == !monitor_mode &&
                  pll_enable == !monitor_mode;
  endproperty
  a_user_on: assert property (p_user_on)
    else $error("watchdog state does not follow mode");

  property p_forced;
    forced_monitor |-> monitor_mode && bus_div4;
  endproperty
  a_forced: assert property (p_forced)
    else $error("forced entry without divide by four");

  // the straps may move once latched; three edges cover the capture
  property p_latched;
    !rst && !$past(rst) && !$past(rst, 2) && !$past(rst, 3)
      |-> $stable(monitor_mode) && $stable(forced_monitor) &&
          $stable(bus_div4);
  endproperty
  a_latched: assert property (p_latched)
    else $error("mode changed after latch");

  property p_div2;
    (monitor_mode && !bus_div4)[*3] |-> $changed(bus_clk);
  endproperty
  a_div2: assert property (p_div2)
    else $error("bus clock not half rate");

  property p_div4;
    bus_div4[*5] |-> bus_clk != $past(bus_clk, 2);
  endproperty
  a_div4: assert property (p_div4)
    else $error("bus clock not quarter rate");

  property p_bit_time;
    oe_q && !host_serial_pin_oe |-> run_q % (bus_div4 ? BIT4 : BIT2) == 0;
  endproperty
  a_bit_time: assert property (p_bit_time)
    else $error("pull-down not a whole number of bits");

  property p_echo;
    rx_strobe |-> ##[0:2] host_serial_pin_oe;
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo did not start with the strobe");

  property p_ready_break;
    $rose(security_done) |-> ##[0:2] host_serial_pin_oe;
  endproperty
  a_ready_break: assert property (p_ready_break)
    else $error("ready break did not start");
endmodule : link_sva

bind monitor_link link_sva u_link_sva (
  .clk, .rst, .host_serial_pin_oe, .monitor_mode, .forced_monitor,
  .bus_div4, .bus_clk, .watchdog_enable, .pll_enable, .security_done,
  .rx_strobe
);

// [bench/host_model.sv]
// host end of the single-wire monitor link
// assumes the bench resolves the wired-OR line with its pullup
module host_model #(
  parameter int BIT = 556
) (
  input  wire logic clk,
  input  wire logic line,
  output logic      host_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] seen_q [$];

  initial host_oe = 1'b0;

  // one frame lsb first; a one only releases, the pullup lifts the line
  task automatic send(input logic [9:0] frame);
    for (int i = 0; i < 10; i++) begin
      #1 host_oe = ~frame[i];
      repeat (BIT) @(posedge clk);
    end
    #1 host_oe = 1'b0;
  endtask : send

  // mid-bit samples of device frames; the stop sample ends early so a
  // start edge right behind it is not missed
  initial forever begin : decode
    logic [9:0] f;
    // a line still held low after a break is not a new start bit
    @(posedge clk iff line === 1'b1);
    @(posedge clk iff (line === 1'b0 && !host_oe));
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      f[i] = line;
      if (i < 9) repeat (BIT) @(posedge clk);
    end
    seen_q.push_back(f);
  end
endmodule : host_model

// [bench/test_monitor_link.sv]
// self-checking bench for the monitor entry link
// assumes the host model on the line and the bound checker
module test_monitor_link;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int B = 556;
  logic       clk, rst, por, hv, er, esel, ms0, ms1, dsel, line, host_oe;
  logic       dev_oe, mon, frc, div4, bclk, wd, pll, claim, sec_done;
  logic       rx_strobe, tx_valid, tx_ready, rx_brk, pin_out;
  logic [7:0] vh, vl, rx_data, tx_data;
  int         miscompares = 0;
  int         check_count = 0;

  // wired-OR line: either side pulls low, the pullup holds it high
  assign line = !(dev_oe || host_oe);

  monitor_link dut (
    .clk(clk), .rst(rst), .power_on_reset(por), .high_test_voltage(hv),
    .reset_vector_high(vh), .reset_vector_low(vl), .entry_select_pin(esel),
    .mode_select_pin_0(ms0), .mode_select_pin_1(ms1),
    .bus_divider_select_pin(dsel), .host_serial_pin_in(line),
    .host_serial_pin_out(pin_out), .host_serial_pin_oe(dev_oe),
    .monitor_mode(mon), .forced_monitor(frc), .bus_div4(div4),
    .bus_clk(bclk), .watchdog_enable(wd), .pll_enable(pll),
    .monitor_pin_claim(claim), .security_done(sec_done),
    .rx_data(rx_data), .rx_strobe(rx_strobe), .rx_break(rx_brk),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready)
  );
  host_model #(.BIT(B)) host (.clk(clk), .line(line), .host_oe(host_oe));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic wait_frames(input int n, input int lim);
    for (int k = 0; k < lim && host.seen_q.size() < n; k++)
      @(posedge clk);
    #1;
  endtask : wait_frames

  // straps {por,hv,erased,esel,ms0,ms1,dsel}; normal /2 last for the link
  task automatic t_modes();
    logic [6:0] st [5] = '{7'h65, 7'h52, 7'h44, 7'h24, 7'h64};
    logic [5:0] ex [5] = '{6'h29, 6'h39, 6'h0E, 6'h0E, 6'h21};
    int n;
    logic b;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      #1 rst = 1'b1;
      {por, hv, er, esel, ms0, ms1, dsel} = st[i];
      {vh, vl} = er ? 16'hFFFF : 16'hFF00;
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk);
      #1 check({mon, frc, div4, wd, pll, claim}, ex[i]);
      {hv, esel, ms0, ms1, dsel} = ~{hv, esel, ms0, ms1, dsel};
      n = 0;
      repeat (16) begin
        b = bclk;
        @(posedge clk);
        #1 n += int'(bclk !== b);
      end
      check(16'(n), ex[i][3] ? 16'h0008 : 16'h0010);
      check({mon, frc, div4, wd, pll, claim}, ex[i]);
    end
  endtask : t_modes

  // fill the transmit buffer until it refuses; nothing drains it yet
  task automatic t_fill();
    tx_valid = 1'b1;
    for (int k = 0; k < 4; k++) begin
      tx_data = 8'h30 + 8'(k);
      for (int n = 0; n < 20 && !tx_ready; n++) begin
        @(posedge clk);
        #1;
      end
      @(posedge clk);
      #1;
    end
    tx_data = 8'h99;
    repeat (3) @(posedge clk);
    #1 check(tx_ready, 1'b0);
    tx_valid = 1'b0;
  endtask : t_fill

  // eight security bytes, each echoed, then the ready break
  task automatic t_security();
    logic [7:0] sb [8] = '{8'h00, 8'hFF, 8'h55, 8'hAA, 8'h01, 8'h80,
                           8'h3C, 8'hC3};
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      host.send({1'b1, sb[i], 1'b0});
      for (int n = 0; n < 3 * B && rx_strobe !== 1'b1; n++) begin
        @(posedge clk);
        #1;
      end
      check(rx_data, sb[i]);
      wait_frames(i + 1, 12 * B);
      check(host.seen_q[i], {1'b1, sb[i], 1'b0});
      check(sec_done, 1'b0);
      repeat (B + B / 2) @(posedge clk);
    end
    wait_frames(9, 12 * B);
    check(sec_done, 1'b1);
    check(host.seen_q[8], 10'h000);
  endtask : t_security

  // held bytes leave in order behind the break; the refused one never
  task automatic t_drain();
    wait_frames(13, 50 * B);
    for (int k = 0; k < 4; k++)
      check(host.seen_q[9 + k], {1'b1, 8'h30 + 8'(k), 1'b0});
    check(tx_ready, 1'b1);
    repeat (B) @(posedge clk);
    #1 check(dev_oe, 1'b0);
    check(16'(host.seen_q.size()), 16'h000D);
  endtask : t_drain

  // host break: pin left high between one and two bits, then ten zeros come back
  // with the break pulse and no byte strobe
  task automatic t_break();
    int hi;
    hi = 0;
    repeat (B) @(posedge clk);
    host.send(10'h000);
    for (int n = 0; n < 3 * B && rx_brk !== 1'b1; n++) begin
      @(posedge clk);
      #1 hi += int'(line === 1'b1);
    end
    check(rx_brk, 1'b1);
    check(rx_strobe, 1'b0);
    check(16'(hi >= B && hi <= 2 * B), 16'h0001);
    check(pin_out, 1'b0);
    wait_frames(14, 12 * B);
    check(host.seen_q[13], 10'h000);
  endtask : t_break

  initial begin
    rst = 1'b1;
    {por, hv, er, esel, ms0, ms1, dsel} = 7'h00;
    {vh, vl, tx_data} = 24'h000000;
    tx_valid = 1'b0;
    t_modes();
    t_fill();
    t_security();
    t_drain();
    t_break();
    close_out();
  end

  // cut a hang well past the expected run of some 140k cycles
  initial begin
    repeat (250000) @(posedge clk);
    miscompares++;
    close_out();
  end
endmodule : test_monitor_link
